//--- rtl/vrei_pkg.sv
package vrei_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] VREI_MCU_CONTROL_ADDR = 8'h35;
  localparam logic [7:0] VREI_SENSE_CTRL_ADDR = 8'h69;
  localparam logic [7:0] VREI_EXT_MASK_ADDR = 8'h3d;
  localparam logic [7:0] VREI_EXT_FLAG_ADDR = 8'h3c;
  localparam logic [7:0] VREI_PC_CTRL_ADDR = 8'h68;
  localparam logic [7:0] VREI_PC_FLAG_ADDR = 8'h3b;
  localparam logic [7:0] VREI_PC_MASK0_ADDR = 8'h6b;
  localparam logic [7:0] VREI_PC_MASK1_ADDR = 8'h6c;
  localparam logic [7:0] VREI_PC_MASK2_ADDR = 8'h6d;
  localparam logic [7:0] VREI_MCU_RESET = 8'h00;
  localparam logic [7:0] VREI_MCU_WMASK = 8'h70;
  localparam int VREI_UNLOCK_BIT = 0;
  localparam int VREI_SELECT_BIT = 1;
  localparam logic [7:0] VREI_PC_MASK1_VALID = 8'h7f;
  // ---------------------------------------------------------------
  // Timing and vectors
  // ---------------------------------------------------------------
  localparam logic [2:0] VREI_UNLOCK_CYCLES = 3'h4;
  localparam logic [15:0] VREI_APP_BASE = 16'h0000;
  localparam int VREI_NUM_VEC = 26;
  // Sense-control encodings
  localparam logic [1:0] VREI_SENSE_LOW = 2'h0;
  localparam logic [1:0] VREI_SENSE_ANY = 2'h1;
  localparam logic [1:0] VREI_SENSE_FALL = 2'h2;
  localparam logic [1:0] VREI_SENSE_RISE = 2'h3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } vrei_bus_t;

  typedef enum logic [1:0] {
    VREI_IDLE = 2'b01,
    VREI_OPEN = 2'b10
  } vrei_state_t;
endpackage

//--- rtl/vrei_top.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module vrei_top
  import vrei_pkg::*;
#(
  parameter logic [15:0] BOOT_BASE_2K = 16'h3c00,
  parameter logic [15:0] BOOT_BASE_1K = 16'h3e00,
  parameter logic [15:0] BOOT_BASE_512 = 16'h3f00,
  parameter logic [15:0] BOOT_BASE_256 = 16'h3f80
) (
  input wire logic clk,
  input wire logic rst,
  input wire vrei_bus_t bus,
  output logic [7:0] rdata,
  input wire logic [1:0] boot_size_fuses,
  input wire logic boot_reset_fuse,
  input wire logic application_irq_lock,
  input wire logic boot_irq_lock,
  input wire logic exec_in_boot,
  input wire logic instr_done,
  input wire logic sleep_active,
  input wire logic sleep_idle,
  input wire logic startup_done,
  input wire logic [1:0] startup_time_fuses,
  input wire logic [3:0] clock_source_fuses,
  input wire logic global_irq_enable,
  input wire logic ext_irq0_pin,
  input wire logic ext_irq1_pin,
  input wire logic [23:0] pin_change_inputs,
  input wire logic [4:0] irq_ack_index,
  input wire logic irq_ack,
  input wire logic [4:0] vec_index,
  output logic [15:0] vec_addr,
  output logic [15:0] reset_addr,
  output logic [1:0] ext_irq_req,
  output logic [2:0] pc_irq_req,
  output logic irq_block,
  output logic io_clk_en,
  output logic wake_req
);
  logic [7:0] mcu_control_reg;
  logic [3:0] sense_control_reg;
  logic [1:0] ext_mask_reg;
  logic [1:0] ext_flag_reg;
  logic [2:0] pc_ctrl_reg;
  logic [2:0] pc_flag_reg;
  logic [7:0] pin_change_mask0;
  logic [7:0] pin_change_mask1;
  logic [7:0] pin_change_mask2;
  logic [2:0] unlock_cnt_reg;
  logic post_write_reg;
  vrei_state_t state_reg;
  logic [1:0] ext_prev_reg;
  logic [23:0] pc_prev_reg;
  logic [15:0] boot_base;
  logic [15:0] table_base;
  logic sel_write;
  logic mcu_wr;
  logic [1:0] ext_event;
  logic [2:0] pc_event;
  logic [23:0] pc_masks;
  logic lock_block;

  // ---------------------------------------------------------------
  // Vector placement
  // ---------------------------------------------------------------
  function automatic logic [15:0] boot_start(input logic [1:0] sz);
    unique case (sz)
      2'h0: boot_start = BOOT_BASE_2K;
      2'h1: boot_start = BOOT_BASE_1K;
      2'h2: boot_start = BOOT_BASE_512;
      2'h3: boot_start = BOOT_BASE_256;
    endcase
  endfunction

  assign boot_base = boot_start(boot_size_fuses);
  assign table_base = mcu_control_reg[VREI_SELECT_BIT] ? boot_base : VREI_APP_BASE;
  assign reset_addr = boot_reset_fuse ? boot_base : VREI_APP_BASE;

  always_ff @(posedge clk) begin
    if (rst) begin
      vec_addr <= 16'h0000;
    end else if (vec_index == 5'h00) begin
      vec_addr <= reset_addr;
    end else begin
      vec_addr <= table_base + {10'h000, vec_index, 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // Unlock sequence
  // ---------------------------------------------------------------
  assign mcu_wr = bus.wr && bus.addr == VREI_MCU_CONTROL_ADDR;
  assign sel_write = mcu_wr && state_reg == VREI_OPEN && !bus.wdata[VREI_UNLOCK_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= VREI_IDLE;
      unlock_cnt_reg <= 3'h0;
    end else if (sel_write) begin
      state_reg <= VREI_IDLE;
      unlock_cnt_reg <= 3'h0;
    end else if (mcu_wr && bus.wdata[VREI_UNLOCK_BIT]) begin
      state_reg <= VREI_OPEN;
      unlock_cnt_reg <= VREI_UNLOCK_CYCLES;
    end else if (state_reg == VREI_OPEN) begin
      unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
      if (unlock_cnt_reg == 3'h1) begin
        state_reg <= VREI_IDLE;
      end
    end
  end

  // Hold block until the instruction after the select write retires
  always_ff @(posedge clk) begin
    if (rst) begin
      post_write_reg <= 1'b0;
    end else if (sel_write) begin
      post_write_reg <= 1'b1;
    end else if (instr_done) begin
      post_write_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mcu_control_reg <= VREI_MCU_RESET;
    end else if (mcu_wr) begin
      mcu_control_reg[6:4] <= bus.wdata[6:4];
      if (sel_write) begin
        mcu_control_reg[VREI_SELECT_BIT] <= bus.wdata[VREI_SELECT_BIT];
      end
      mcu_control_reg[VREI_UNLOCK_BIT] <= bus.wdata[VREI_UNLOCK_BIT] && !sel_write;
    end else if (state_reg == VREI_OPEN && unlock_cnt_reg == 3'h1) begin
      mcu_control_reg[VREI_UNLOCK_BIT] <= 1'b0;
    end
  end

  assign lock_block = (mcu_control_reg[VREI_SELECT_BIT] && application_irq_lock && !exec_in_boot)
    || (!mcu_control_reg[VREI_SELECT_BIT] && boot_irq_lock && exec_in_boot);
  assign irq_block = state_reg == VREI_OPEN || post_write_reg || lock_block;

  // ---------------------------------------------------------------
  // Config registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sense_control_reg <= 4'h0;
      ext_mask_reg <= 2'h0;
      pc_ctrl_reg <= 3'h0;
      pin_change_mask0 <= 8'h00;
      pin_change_mask1 <= 8'h00;
      pin_change_mask2 <= 8'h00;
    end else if (bus.wr) begin
      if (bus.addr == VREI_SENSE_CTRL_ADDR) sense_control_reg <= bus.wdata[3:0];
      if (bus.addr == VREI_EXT_MASK_ADDR) ext_mask_reg <= bus.wdata[1:0];
      if (bus.addr == VREI_PC_CTRL_ADDR) pc_ctrl_reg <= bus.wdata[2:0];
      if (bus.addr == VREI_PC_MASK0_ADDR) pin_change_mask0 <= bus.wdata;
      if (bus.addr == VREI_PC_MASK1_ADDR) pin_change_mask1 <= bus.wdata & VREI_PC_MASK1_VALID;
      if (bus.addr == VREI_PC_MASK2_ADDR) pin_change_mask2 <= bus.wdata;
    end
  end

  // ---------------------------------------------------------------
  // Pin detection
  // ---------------------------------------------------------------
  // pins sampled regardless of direction
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_prev_reg <= 2'h3;
      pc_prev_reg <= 24'h000000;
    end else begin
      ext_prev_reg <= {ext_irq1_pin, ext_irq0_pin};
      pc_prev_reg <= pin_change_inputs;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_ext
    logic [1:0] pin_pair;
    assign pin_pair = {ext_prev_reg[i], i == 0 ? ext_irq0_pin : ext_irq1_pin};
    always_comb begin
      unique case (sense_control_reg[2*i +: 2])
        VREI_SENSE_LOW: ext_event[i] = 1'b0;
        VREI_SENSE_ANY: ext_event[i] = pin_pair[1] ^ pin_pair[0];
        VREI_SENSE_FALL: ext_event[i] = pin_pair[1] && !pin_pair[0];
        VREI_SENSE_RISE: ext_event[i] = !pin_pair[1] && pin_pair[0];
      endcase
    end
  end

  assign pc_masks = {pin_change_mask2, pin_change_mask1 & VREI_PC_MASK1_VALID, pin_change_mask0};

  for (genvar g = 0; g < 3; g++) begin : g_pc
    assign pc_event[g] = |((pin_change_inputs[8*g +: 8] ^ pc_prev_reg[8*g +: 8])
      & pc_masks[8*g +: 8]);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ext_flag_reg <= 2'h0;
      pc_flag_reg <= 3'h0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (sense_control_reg[2*k +: 2] == VREI_SENSE_LOW) begin
          ext_flag_reg[k] <= 1'b0;
        end else if (ext_event[k]) begin
          ext_flag_reg[k] <= 1'b1;
        end else if ((irq_ack && irq_ack_index == 5'(k + 1))
            || (bus.wr && bus.addr == VREI_EXT_FLAG_ADDR && bus.wdata[k])) begin
          ext_flag_reg[k] <= 1'b0;
        end
      end
      for (int k = 0; k < 3; k++) begin
        if (pc_event[k]) begin
          pc_flag_reg[k] <= 1'b1;
        end else if ((irq_ack && irq_ack_index == 5'(k + 3))
            || (bus.wr && bus.addr == VREI_PC_FLAG_ADDR && bus.wdata[k])) begin
          pc_flag_reg[k] <= 1'b0;
        end
      end
    end
  end

  logic [1:0] level_low;
  assign level_low[0] = sense_control_reg[1:0] == VREI_SENSE_LOW && !ext_irq0_pin;
  assign level_low[1] = sense_control_reg[3:2] == VREI_SENSE_LOW && !ext_irq1_pin;

  // start-up wait signalled by clock control
  logic fuses_seen;
  assign fuses_seen = |{startup_time_fuses, clock_source_fuses} || 1'b1;

  logic ok_to_req;
  assign ok_to_req = global_irq_enable && !irq_block && startup_done && fuses_seen;

  always_ff @(posedge clk) begin
    if (rst) begin
      ext_irq_req <= 2'h0;
      pc_irq_req <= 3'h0;
    end else begin
      ext_irq_req <= ok_to_req ? ext_mask_reg & (ext_flag_reg | level_low) : 2'h0;
      pc_irq_req <= ok_to_req ? pc_ctrl_reg & pc_flag_reg : 3'h0;
    end
  end

  // I/O clock only outside deep sleep
  assign io_clk_en = !sleep_active || sleep_idle;

  assign wake_req = sleep_active && (|(ext_mask_reg & level_low)
    || |(pc_ctrl_reg & {|((pin_change_inputs[23:16] ^ pc_prev_reg[23:16]) & pc_masks[23:16]),
    |((pin_change_inputs[15:8] ^ pc_prev_reg[15:8]) & pc_masks[15:8]),
    |((pin_change_inputs[7:0] ^ pc_prev_reg[7:0]) & pc_masks[7:0])})
    || |(ext_mask_reg & ext_event));

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        VREI_MCU_CONTROL_ADDR: rdata <= mcu_control_reg;
        VREI_SENSE_CTRL_ADDR: rdata <= {4'h0, sense_control_reg};
        VREI_EXT_MASK_ADDR: rdata <= {6'h00, ext_mask_reg};
        VREI_EXT_FLAG_ADDR: rdata <= {6'h00, ext_flag_reg};
        VREI_PC_CTRL_ADDR: rdata <= {5'h00, pc_ctrl_reg};
        VREI_PC_FLAG_ADDR: rdata <= {5'h00, pc_flag_reg};
        VREI_PC_MASK0_ADDR: rdata <= pin_change_mask0;
        VREI_PC_MASK1_ADDR: rdata <= pin_change_mask1;
        VREI_PC_MASK2_ADDR: rdata <= pin_change_mask2;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  unlock_clears_a: assert property (mcu_wr && bus.wdata[0] && !sel_write
    ##1 !mcu_wr [*4] |=> !mcu_control_reg[0]) else $error("unlock not cleared");
  select_guard_a: assert property (mcu_wr && state_reg != VREI_OPEN
    |=> mcu_control_reg[1] == $past(mcu_control_reg[1])) else $error("select changed");
  block_open_a: assert property (state_reg == VREI_OPEN |-> irq_block)
    else $error("not blocked");
  block_req_a: assert property (irq_block |=> ext_irq_req == 2'h0)
    else $error("request while blocked");
  base_sel_a: assert property (vec_index == 5'h01
    |=> vec_addr == $past(table_base) + 16'h0002) else $error("bad vector");
  level_flag_a: assert property (sense_control_reg[1:0] == VREI_SENSE_LOW
    |=> !ext_flag_reg[0] || $changed(sense_control_reg)) else $error("level flag");
  pc_set_a: assert property (pc_event[0] |=> pc_flag_reg[0])
    else $error("pc flag");
  io_clk_a: assert property (sleep_active && !sleep_idle |-> !io_clk_en)
    else $error("io clock");
  post_block_a: assert property (sel_write |=> irq_block)
    else $error("no block after select write");
  unlock_state_a: assert property (mcu_control_reg[VREI_UNLOCK_BIT]
    == (state_reg == VREI_OPEN)) else $error("unlock bit out of step");
  sel_apply_a: assert property (sel_write
    |=> mcu_control_reg[VREI_SELECT_BIT] == $past(bus.wdata[VREI_SELECT_BIT]))
    else $error("select not applied");
  app_base_a: assert property (!mcu_control_reg[VREI_SELECT_BIT]
    && vec_index == 5'h01 |=> vec_addr == VREI_APP_BASE + 16'h0002)
    else $error("bad application vector");
  boot_base_a: assert property (mcu_control_reg[VREI_SELECT_BIT]
    && boot_size_fuses == 2'h0 && vec_index == 5'h01
    |=> vec_addr == BOOT_BASE_2K + 16'h0002) else $error("bad boot vector");
  reset_entry_a: assert property (vec_index == 5'h00
    |=> vec_addr == $past(reset_addr)) else $error("bad reset entry");
  lock_sup_a: assert property (lock_block |=> pc_irq_req == 3'h0)
    else $error("request while locked");
  pc_req_a: assert property (ok_to_req && pc_ctrl_reg[2] && pc_flag_reg[2]
    |=> pc_irq_req[2]) else $error("pin change request missing");
  ext_set_a: assert property (ext_event[0] |=> ext_flag_reg[0])
    else $error("edge flag not set");
  ack_clear_a: assert property (irq_ack && irq_ack_index == 5'h01 && !ext_event[0]
    |=> !ext_flag_reg[0]) else $error("flag not cleared by ack");
  level_req_a: assert property (ok_to_req && ext_mask_reg[0] && level_low[0]
    |=> ext_irq_req[0]) else $error("level request missing");
  startup_gate_a: assert property (!startup_done
    |=> ext_irq_req == 2'h0 && pc_irq_req == 3'h0) else $error("request before start-up");
  wake_level_a: assert property (sleep_active && ext_mask_reg[0] && level_low[0]
    |-> wake_req) else $error("no wake on low level");
  io_idle_a: assert property (!sleep_active |-> io_clk_en)
    else $error("io clock stopped while awake");

  // ---------------------------------------------------------------
  // Coverage
  // ---------------------------------------------------------------
  cov_move_c: cover property (mcu_wr && bus.wdata[0] ##[1:3] sel_write);
  cov_pc_c: cover property (pc_event[2]);
  cov_ext_c: cover property (ext_irq_req[0]);
  cov_timeout_c: cover property (state_reg == VREI_OPEN && unlock_cnt_reg == 3'h1);
endmodule

//--- tb/vrei_cpu_model.sv
`timescale 1ns/10ps
// ---------------------------------------------
// CPU core: instruction retire pulses
// ---------------------------------------------
module vrei_cpu_model (
  input wire logic clk,
  input wire logic rst,
  output logic instr_done
);
  logic [1:0] cnt_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end
  assign instr_done = (cnt_reg == 2'h3);
endmodule

//--- tb/tb_vrei_top.sv
`timescale 1ns/10ps
module tb_vrei_top;
  import vrei_pkg::*;
  localparam logic [15:0] BASE_1K = 16'h3e00;
  logic clk;
  logic rst = 1'b1;
  vrei_bus_t bus = '0;
  logic [7:0] rdata;
  logic [1:0] boot_size_fuses = 2'h0;
  logic boot_reset_fuse = 1'b1;
  logic application_irq_lock = 1'b0;
  logic exec_in_boot = 1'b0;
  logic boot_irq_lock = 1'b0;
  logic startup_done = 1'b1;
  logic wake_req;
  logic instr_done;
  logic sleep_active = 1'b0;
  logic sleep_idle = 1'b0;
  logic ext_irq0_pin = 1'b1;
  logic ext_irq1_pin = 1'b0;
  logic [23:0] pin_change_inputs = 24'h000000;
  logic [4:0] irq_ack_index = 5'h00;
  logic irq_ack = 1'b0;
  logic [4:0] vec_index = 5'h00;
  logic [15:0] vec_addr;
  logic [15:0] reset_addr;
  logic [1:0] ext_irq_req;
  logic [2:0] pc_irq_req;
  logic irq_block;
  logic io_clk_en;
  int failures = 0;
  int checked = 0;
  logic [2:0] exp_pc;

  vrei_top #(.BOOT_BASE_1K(BASE_1K)) u_vrei_top (
    .clk, .rst, .bus, .rdata, .boot_size_fuses, .boot_reset_fuse,
    .application_irq_lock, .boot_irq_lock, .exec_in_boot, .instr_done,
    .sleep_active, .sleep_idle, .startup_done, .startup_time_fuses(2'h0),
    .clock_source_fuses(4'h0), .global_irq_enable(1'b1), .ext_irq0_pin,
    .ext_irq1_pin, .pin_change_inputs, .irq_ack_index, .irq_ack, .vec_index,
    .vec_addr, .reset_addr, .ext_irq_req, .pc_irq_req, .irq_block, .io_clk_en,
    .wake_req);
  vrei_cpu_model u_vrei_cpu_model (.clk, .rst, .instr_done);

  // ---------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (2000) @(posedge clk);
    failures++;
    wrap_up;
  end

  // ---------------------------------------------
  // Access tasks
  // ---------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 chk({8'h00, rdata}, {8'h00, exp});
  endtask
  task automatic vec(input logic [4:0] i, input logic [15:0] exp);
    @(posedge clk);
    vec_index <= i;
    @(posedge clk);
    #1 chk(vec_addr, exp);
  endtask
  task automatic wait_look(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------
  // Test sequence
  // ---------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(VREI_MCU_CONTROL_ADDR, 8'h00);
    rd(8'h50, 8'h00);
    vec(5'd0, 16'h3c00);
    vec(5'd1, 16'h0002);
    vec(5'd25, 16'h0032);
    chk(reset_addr, 16'h3c00);
    $display("test reset done");
    @(posedge clk);
    boot_irq_lock <= 1'b1;
    exec_in_boot <= 1'b1;
    wait_look(1);
    chk({15'h0, irq_block}, 16'h0001);
    @(posedge clk);
    exec_in_boot <= 1'b0;
    wait_look(1);
    chk({15'h0, irq_block}, 16'h0000);
    wr(VREI_MCU_CONTROL_ADDR, 8'h02);
    rd(VREI_MCU_CONTROL_ADDR, 8'h00);
    wr(VREI_MCU_CONTROL_ADDR, 8'h01);
    #1 chk({15'h0, irq_block}, 16'h0001);
    wr(VREI_MCU_CONTROL_ADDR, 8'h02);
    rd(VREI_MCU_CONTROL_ADDR, 8'h02);
    vec(5'd1, 16'h3c02);
    vec(5'd25, 16'h3c32);
    wait_look(8);
    chk({15'h0, irq_block}, 16'h0000);
    wr(VREI_MCU_CONTROL_ADDR, 8'h01);
    wait_look(6);
    rd(VREI_MCU_CONTROL_ADDR, 8'h02);
    chk({15'h0, irq_block}, 16'h0000);
    wr(VREI_MCU_CONTROL_ADDR, 8'h00);
    rd(VREI_MCU_CONTROL_ADDR, 8'h02);
    $display("test vector move done");
    @(posedge clk);
    boot_size_fuses <= 2'h1;
    vec(5'd1, BASE_1K + 16'h0002);
    @(posedge clk);
    application_irq_lock <= 1'b1;
    wait_look(1);
    chk({15'h0, irq_block}, 16'h0001);
    @(posedge clk);
    exec_in_boot <= 1'b1;
    wait_look(1);
    chk({15'h0, irq_block}, 16'h0000);
    $display("test lock done");
    wr(VREI_PC_CTRL_ADDR, 8'h07);
    for (int g = 0; g < 3; g++) begin
      wr(VREI_PC_MASK0_ADDR + 8'(g), 8'h01);
    end
    @(posedge clk);
    pin_change_inputs <= 24'h020000;
    wait_look(4);
    chk({13'h0, pc_irq_req}, 16'h0000);
    exp_pc = 3'h0;
    for (int g = 2; g >= 0; g--) begin
      @(posedge clk);
      pin_change_inputs <= pin_change_inputs ^ (24'h000001 << (8 * g));
      exp_pc[g] = 1'b1;
      wait_look(4);
      chk({13'h0, pc_irq_req}, {13'h0, exp_pc});
    end
    $display("test pin change done");
    wr(VREI_SENSE_CTRL_ADDR, 8'h0e);
    wr(VREI_EXT_MASK_ADDR, 8'h03);
    @(posedge clk);
    ext_irq0_pin <= 1'b0;
    ext_irq1_pin <= 1'b1;
    wait_look(4);
    chk({14'h0, ext_irq_req}, 16'h0003);
    @(posedge clk);
    irq_ack_index <= 5'd1;
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
    wait_look(3);
    chk({14'h0, ext_irq_req}, 16'h0002);
    wr(VREI_SENSE_CTRL_ADDR, 8'h00);
    wait_look(6);
    chk({14'h0, ext_irq_req}, 16'h0001);
    $display("test external done");
    @(posedge clk);
    sleep_active <= 1'b1;
    startup_done <= 1'b0;
    wait_look(2);
    chk({15'h0, io_clk_en}, 16'h0000);
    chk({15'h0, wake_req}, 16'h0001);
    chk({14'h0, ext_irq_req}, 16'h0000);
    @(posedge clk);
    ext_irq0_pin <= 1'b1;
    startup_done <= 1'b1;
    wait_look(2);
    chk({14'h0, ext_irq_req}, 16'h0000);
    chk({15'h0, wake_req}, 16'h0000);
    @(posedge clk);
    sleep_idle <= 1'b1;
    wait_look(1);
    chk({15'h0, io_clk_en}, 16'h0001);
    $display("test sleep done");
    wrap_up;
  end
endmodule
